/* File: hw/e1m_txmux.sv */
// Purpose: Transmit multiplexed bus input, splits two byte-interleaved buses into slot words
// Assumes: Bus pins are asynchronous to pclk and sampled at 200 MHz
// Notes: Edge, polarity and rate settings that must be common are taken as described below
//
// How it works
// - Two shared buses; each framer picks one with its bus choice bit.
// - Each bus interleaves bytes of up to four framers; bytes go to owners.
// - Frame pulse sampled on frame edge, data and signaling on data edge.
// - Differing edge settings put the frame edge one edge before data edge.
// - Clock rate double picks 8.192 MHz or 16.384 MHz bus clock.
// - In double rate, edge phase picks which active edge samples data.
// - In double rate, frame pulse is sampled on the first active edge.
// - Rate double and edge phase are ORed across all eight framers.
// - Frame pulse polarity bit sets the active level of the pulse.
// - Data line runs at 8.192 Mb/s, four interleaved E1 streams.
// - Signaling replaces slot 16 only with COMMON_CHANNEL_SIGNALING off and source select zero.
// - Bit 1 of every slot byte comes first on the bus.
// - A non-zero slot offset delays a framer's frame after the pulse.

`timescale 1ns/1ps
`include "e1m_defs.svh"

module e1m_txmux
	import e1m_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`E1M_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Multiplexed bus pins
	input wire logic mux_bus_clock,
	input wire logic mux_frame_pulse,
	input wire logic [1:0] mux_tx_data,
	input wire logic [1:0] mux_tx_signaling,
	output logic mux_frame_pulse_out,
	// Slot word stream
	input wire logic slot_ready,
	output logic slot_valid,
	output e1m_word_t slot_word
);

	// ************************************************
	// Declarations
	// ************************************************
	localparam int LW = $clog2(`E1M_FIFO_DEPTH) + 1;
	localparam logic [3:0] NREG = 4'ha;

	e1m_cfg_set_t cfg_q, next_cfg;
	logic enable, next_enable, ovf, next_ovf, seen, next_seen;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, setup, wr;
	logic [3:0] rsel;
	logic [LW-1:0] level;
	logic [5:0] pin_s1, pin_s2;
	logic clk_prev, fp_prev, next_fp_prev, fp_pend, next_fp_pend;
	logic start_pend, next_start_pend, phase, next_phase, phase_n;
	logic rise, fall, fe_edge, de_edge, fp_level, fp_hit, fp_now, take, start;
	logic rate_dbl_eff, edge_phase_eff, next_fp_out;
	logic [`E1M_BITCNT_W-1:0] bit_cnt, next_bit_cnt, cur;
	logic byte_done, next_byte_done;
	logic [6:0] byte_idx, next_byte_idx;
	logic [7:0] data_sh [`E1M_NBUS];
	logic [7:0] sig_sh [`E1M_NBUS];
	e1m_own_t own [`E1M_NBUS];
	e1m_word_t wnew [`E1M_NBUS];
	e1m_word_t pw [`E1M_NBUS];
	e1m_word_t next_pw [`E1M_NBUS];
	logic [1:0] pend, next_pend;
	logic ovf_set, fifo_in_valid, fifo_in_ready;
	e1m_word_t fifo_in_data;

	// Register index from a byte address, NREG when unmapped
	function automatic logic [3:0] reg_sel(input logic [`E1M_ADDR_W-1:0] a);
		reg_sel = NREG;
		if (a[1:0] == 2'h0) begin
			if (a < `E1M_STATUS_OFS) begin
				reg_sel = a[5:2];
			end else if (a == `E1M_STATUS_OFS) begin
				reg_sel = 4'h8;
			end else if (a == `E1M_CTRL_OFS) begin
				reg_sel = 4'h9;
			end
		end
	endfunction : reg_sel

	// Owner of an interleaved byte; lowest framer wins a clash
	function automatic e1m_own_t find_owner(input e1m_cfg_set_t c, input logic bus,
		input logic [6:0] idx);
		logic [6:0] diff;
		find_owner = '0;
		diff = '0;
		for (int n = `E1M_NFRAMERS - 1; n >= 0; n--) begin
			diff = idx - c[n].offset;
			if (c[n].bus == bus && diff[1:0] == 2'h0) begin
				find_owner.hit = 1'b1;
				find_owner.framer = 3'(n);
				find_owner.slot = diff[6:2];
				find_owner.ts16_sub = (diff[6:2] == `E1M_TS16) & ~c[n].common_channel_signaling & ~c[n].sig_src;
			end
		end
	endfunction : find_owner

	// ************************************************
	// APB registers
	// ************************************************
	always_comb begin
		setup = psel & ~penable;
		wr = psel & penable & pready & pwrite;
		rsel = reg_sel(paddr);
		next_pready = setup;
		next_prdata = prdata;
		next_pslverr = pslverr;
		next_cfg = cfg_q;
		next_enable = enable;
		next_ovf = ovf;
		if (setup) begin
			next_pslverr = (rsel == NREG);
			next_prdata = '0;
			if (rsel < 4'h8) begin
				next_prdata[`E1M_CFG_W-1:0] = cfg_q[rsel[2:0]];
			end else if (rsel == 4'h8) begin
				next_prdata[`E1M_ST_OVF_BIT] = ovf;
				next_prdata[`E1M_ST_SEEN_BIT] = seen;
				next_prdata[`E1M_ST_LEVEL_LSB +: LW] = level;
			end else if (rsel == 4'h9) begin
				next_prdata[`E1M_CTRL_EN_BIT] = enable;
			end
		end
		if (wr && rsel < 4'h8) begin
			next_cfg[rsel[2:0]] = pwdata[`E1M_CFG_W-1:0];
		end
		if (wr && rsel == 4'h9) begin
			next_enable = pwdata[`E1M_CTRL_EN_BIT];
		end
		if (wr && rsel == 4'h8 && pwdata[`E1M_ST_OVF_BIT]) begin
			next_ovf = 1'b0;
		end
		// A new overflow beats a clear in the same cycle
		if (ovf_set) begin
			next_ovf = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
			cfg_q <= '0;
			enable <= `E1M_CTRL_RESET;
			ovf <= 1'b0;
		end else begin
			pready <= next_pready;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			cfg_q <= next_cfg;
			enable <= next_enable;
			ovf <= next_ovf;
		end
	end

	// ************************************************
	// Pin capture and bit timing
	// ************************************************
	always_comb begin
		rate_dbl_eff = 1'b0;
		edge_phase_eff = 1'b0;
		for (int n = 0; n < `E1M_NFRAMERS; n++) begin
			rate_dbl_eff = rate_dbl_eff | cfg_q[n].rate_dbl;
			edge_phase_eff = edge_phase_eff | cfg_q[n].edge_phase;
		end
		rise = pin_s2[5] & ~clk_prev;
		fall = ~pin_s2[5] & clk_prev;
		// edge choice; framer 0 holds the shared settings
		fe_edge = cfg_q[0].fe ? fall : rise;
		de_edge = cfg_q[0].de ? fall : rise;
		fp_level = pin_s2[4] ^ cfg_q[0].fp_pol;
		// first active edge of the pulse only
		fp_hit = fe_edge & fp_level & ~fp_prev;
		next_fp_prev = fe_edge ? fp_level : fp_prev;
		fp_now = fp_pend | fp_hit;
		// double rate picks one of two edges per bit
		phase_n = fp_now ? 1'b0 : ~phase;
		take = de_edge & (~rate_dbl_eff | (phase_n == edge_phase_eff));
		start = start_pend | fp_now;
		next_phase = (de_edge & rate_dbl_eff) ? phase_n : phase;
		next_fp_pend = fp_pend;
		if (fp_hit & ~de_edge) begin
			next_fp_pend = 1'b1;
		end else if (de_edge) begin
			next_fp_pend = 1'b0;
		end
		next_start_pend = start_pend;
		if (de_edge & fp_now) begin
			next_start_pend = 1'b1;
		end
		if (take) begin
			next_start_pend = 1'b0;
		end
		// frame of 1024 bits restarts at the pulse
		cur = (take & start) ? '0 : bit_cnt;
		next_bit_cnt = take ? cur + 1'b1 : bit_cnt;
		next_byte_done = take & seen & (cur[2:0] == 3'h7);
		next_byte_idx = take ? cur[9:3] : byte_idx;
		next_fp_out = take & start;
		next_seen = seen | (take & start);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			clk_prev <= 1'b0;
			fp_prev <= 1'b0;
			fp_pend <= 1'b0;
			start_pend <= 1'b0;
			phase <= 1'b0;
			bit_cnt <= '0;
			byte_done <= 1'b0;
			byte_idx <= '0;
			mux_frame_pulse_out <= 1'b0;
			seen <= 1'b0;
		end else begin
			pin_s1 <= {mux_bus_clock, mux_frame_pulse, mux_tx_data, mux_tx_signaling};
			pin_s2 <= pin_s1;
			clk_prev <= pin_s2[5];
			fp_prev <= next_fp_prev;
			fp_pend <= next_fp_pend;
			start_pend <= next_start_pend;
			phase <= next_phase;
			bit_cnt <= next_bit_cnt;
			byte_done <= next_byte_done;
			byte_idx <= next_byte_idx;
			mux_frame_pulse_out <= next_fp_out;
			seen <= next_seen;
		end
	end

	// ************************************************
	// Per-bus byte assembly and ownership
	// ************************************************
	for (genvar g = 0; g < `E1M_NBUS; g++) begin : g_bus
		logic [7:0] next_dsh, next_ssh;
		always_comb begin
			// bit 1 first, lands in the msb
			next_dsh = take ? {data_sh[g][6:0], pin_s2[2+g]} : data_sh[g];
			next_ssh = take ? {sig_sh[g][6:0], pin_s2[g]} : sig_sh[g];
			// owner by bus choice and offset
			own[g] = find_owner(cfg_q, 1'(g), byte_idx);
			wnew[g].framer = own[g].framer;
			wnew[g].slot = own[g].slot;
			wnew[g].data = own[g].ts16_sub ? sig_sh[g] : data_sh[g];
			wnew[g].sig = sig_sh[g][3:0];
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				data_sh[g] <= '0;
				sig_sh[g] <= '0;
			end else begin
				data_sh[g] <= next_dsh;
				sig_sh[g] <= next_ssh;
			end
		end
	end

	// ************************************************
	// Hand-off to the FIFO
	// ************************************************
	// Bus 0 goes first; a word still waiting at the next byte is an overflow
	always_comb begin
		fifo_in_valid = |pend;
		fifo_in_data = pend[0] ? pw[0] : pw[1];
		next_pend = pend;
		next_pw = pw;
		ovf_set = 1'b0;
		if (fifo_in_valid & fifo_in_ready) begin
			if (pend[0]) begin
				next_pend[0] = 1'b0;
			end else begin
				next_pend[1] = 1'b0;
			end
		end
		if (byte_done & enable) begin
			ovf_set = |next_pend;
			next_pend = {own[1].hit, own[0].hit};
			next_pw = wnew;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= '0;
			pw <= '{default: '0};
		end else begin
			pend <= next_pend;
			pw <= next_pw;
		end
	end

	e1m_fifo #(
		.WIDTH($bits(e1m_word_t)),
		.DEPTH(`E1M_FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_ready(slot_ready),
		.out_valid(slot_valid),
		.out_data(slot_word),
		.level(level)
	);

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not one cycle after setup");
	single_rate_a: assert property (de_edge && !rate_dbl_eff |-> take)
		else $error("single rate data edge not sampled");
	phase_pick_a: assert property (take && rate_dbl_eff |-> phase_n == edge_phase_eff)
		else $error("double rate sampled on wrong edge");
	pulse_first_a: assert property (fp_hit |-> fe_edge && !fp_prev)
		else $error("frame pulse taken past first edge");
	frame_reset_a: assert property (take && start |=> bit_cnt == 10'h001 && mux_frame_pulse_out)
		else $error("frame start did not restart bit count");
	byte_end_a: assert property (take && seen && cur[2:0] == 3'h7 |=> byte_done ##1 !byte_done)
		else $error("byte completion pulse wrong");
	owner_slot_a: assert property (byte_done && own[0].hit |->
		((byte_idx - cfg_q[own[0].framer].offset) & 7'h03) == 7'h00)
		else $error("byte owner offset mismatch");
	bus_owner_a: assert property (byte_done && own[1].hit |-> cfg_q[own[1].framer].bus)
		else $error("bus 1 byte given to bus 0 framer");
	ts16_sub_a: assert property (byte_done && enable && own[0].hit && own[0].ts16_sub |=>
		pw[0].data == $past(sig_sh[0]))
		else $error("slot 16 not replaced by signaling");
	ovf_keep_a: assert property (ovf && !(wr && rsel == 4'h8 && pwdata[0]) |=> ovf)
		else $error("overflow flag lost");

endmodule : e1m_txmux

/* File: hw/e1m_defs.svh */
// Purpose: Offsets, field positions, reset values and counts of the mux input
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Definitions only

`ifndef E1M_DEFS_SVH
`define E1M_DEFS_SVH

// ************************************************
// Register map (byte addresses)
// ************************************************
`define E1M_CFG_BASE 8'h00
`define E1M_STATUS_OFS 8'h20
`define E1M_CTRL_OFS 8'h24
`define E1M_ADDR_W 8

// ************************************************
// Field positions and reset values
// ************************************************
`define E1M_CFG_W 16
`define E1M_CFG_RESET 16'h0000
`define E1M_ST_OVF_BIT 0
`define E1M_ST_SEEN_BIT 1
`define E1M_ST_LEVEL_LSB 8
`define E1M_CTRL_EN_BIT 0
`define E1M_CTRL_RESET 1'b0

// ************************************************
// Sizes and frame counts
// ************************************************
`define E1M_NFRAMERS 8
`define E1M_NBUS 2
`define E1M_FIFO_DEPTH 32
`define E1M_BITCNT_W 10
`define E1M_TS16 5'h10

`endif

/* File: hw/e1m_pkg.sv */
// Purpose: Types shared by the mux input design
// Assumes: Constants live in e1m_defs.svh
// Notes: Config struct packs the per-framer register word, msb first

package e1m_pkg;

	// ************************************************
	// Per-framer configuration word
	// ************************************************
	typedef struct packed {
		logic sig_src;
		logic common_channel_signaling;
		logic fp_pol;
		logic edge_phase;
		logic rate_dbl;
		logic de;
		logic fe;
		logic bus;
		logic spare;
		logic [6:0] offset;
	} e1m_cfg_t;

	typedef e1m_cfg_t [7:0] e1m_cfg_set_t;

	// ************************************************
	// Captured slot word and ownership result
	// ************************************************
	typedef struct packed {
		logic [2:0] framer;
		logic [4:0] slot;
		logic [7:0] data;
		logic [3:0] sig;
	} e1m_word_t;

	typedef struct packed {
		logic hit;
		logic [2:0] framer;
		logic [4:0] slot;
		logic ts16_sub;
	} e1m_own_t;

endpackage : e1m_pkg

/* File: hw/e1m_fifo.sv */
// Purpose: Slot word FIFO with a registered output stage
// Assumes: Single clock, drain side may stall at will
// Notes: level counts stored words plus the output stage

`timescale 1ns/1ps

module e1m_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	input wire logic out_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	// Fill level
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] cnt, next_cnt;
	logic next_out_valid;
	logic [WIDTH-1:0] next_out_data;
	logic push, pop;

	// ************************************************
	// Pointer and count update
	// ************************************************
	always_comb begin
		in_ready = (cnt != (AW+1)'(DEPTH));
		push = in_valid & in_ready;
		pop = (cnt != '0) & (~out_valid | out_ready);
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_cnt = cnt;
		if (push & ~pop) begin
			next_cnt = cnt + 1'b1;
		end else if (pop & ~push) begin
			next_cnt = cnt - 1'b1;
		end
		next_out_valid = out_valid;
		next_out_data = out_data;
		if (pop) begin
			next_out_valid = 1'b1;
			next_out_data = mem[rd_ptr];
		end else if (out_ready) begin
			next_out_valid = 1'b0;
		end
		level = cnt + {{AW{1'b0}}, out_valid};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			cnt <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			cnt <= next_cnt;
			out_valid <= next_out_valid;
			out_data <= next_out_data;
		end
	end

	// Storage has no reset: contents are only read after a push
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

endmodule : e1m_fifo

/* File: bench/e1m_bus_model.sv */
// Purpose: Backplane driver model for the two multiplexed transmit buses
// Assumes: Active edges rising unless set otherwise; clock idles high
// Notes: Clock stands still between frames; released lines show inverse

`timescale 1ns/1ps

module e1m_bus_model (
	// Bus pins
	output logic mux_bus_clock,
	output logic mux_frame_pulse,
	output logic [1:0] mux_tx_data,
	output logic [1:0] mux_tx_signaling
);
	// ****
	// Frame driver
	// ****
	initial begin
		mux_bus_clock = 1'b1;
		mux_frame_pulse = 1'b0;
		mux_tx_data = 2'h0;
		mux_tx_signaling = 2'h3;
	end

	// Kind 1 is the signaling byte
	function automatic logic [7:0] pat(input int b, input int i, input int kind);
		return 8'(i * 37 + b * 101 + kind * 59 + 3);
	endfunction : pat

	task automatic send(input int nb, input bit dbl, input bit ph, input bit inv);
		logic [1:0] d;
		logic [1:0] s;
		logic [7:0] v;
		for (int i = 0; i < nb; i++) begin
			for (int k = 0; k < 8; k++) begin
				for (int b = 0; b < 2; b++) begin
					v = pat(b, i, 0);
					d[b] = v[7 - k];
					v = pat(b, i, 1);
					s[b] = v[7 - k];
				end
				mux_frame_pulse = (i == 0 && k == 0) ^ inv;
				if (!dbl) begin
					mux_tx_data = d;
					mux_tx_signaling = s;
					#40 mux_bus_clock = 1'b0;
					#80 mux_bus_clock = 1'b1;
					#40;
				end else begin
					// wrong value at the unused phase
					mux_tx_data = ph ? ~d : d;
					mux_tx_signaling = ph ? ~s : s;
					#20 mux_bus_clock = 1'b0;
					#40 mux_bus_clock = 1'b1;
					#20 mux_frame_pulse = inv;
					mux_tx_data = ph ? d : ~d;
					mux_tx_signaling = ph ? s : ~s;
					#20 mux_bus_clock = 1'b0;
					#40 mux_bus_clock = 1'b1;
					#20;
				end
			end
		end
		mux_frame_pulse = inv;
		mux_tx_data = ~mux_tx_data;
		mux_tx_signaling = ~mux_tx_signaling;
	endtask : send
endmodule : e1m_bus_model

/* File: bench/e1m_txmux_bench.sv */
// Purpose: Self-checking bench for the multiplexed bus input
// Assumes: APB slave may add wait states, bus pins async to pclk
// Notes: Expected words are built from the config and the bus pattern

`timescale 1ns/1ps
`include "e1m_defs.svh"

module e1m_txmux_bench import e1m_pkg::*; ();
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slot_ready = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, err, mux_bus_clock, mux_frame_pulse, mux_frame_pulse_out, slot_valid;
	logic [1:0] mux_tx_data, mux_tx_signaling;
	e1m_word_t slot_word;
	e1m_word_t exq[$];
	e1m_cfg_set_t cfgs;
	int n_fail = 0, comparisons = 0, n_fp = 0, n_drain = 0, l;
	bit drop = 0;

	always #2.5 pclk = ~pclk;

	e1m_txmux u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .mux_bus_clock, .mux_frame_pulse, .mux_tx_data,
		.mux_tx_signaling, .mux_frame_pulse_out, .slot_ready, .slot_valid, .slot_word);
	e1m_bus_model u_bus (.mux_bus_clock, .mux_frame_pulse, .mux_tx_data, .mux_tx_signaling);

	// ****
	// Checks and bus tasks
	// ****
	task automatic bad(input string m);
		n_fail++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : bad

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e) bad($sformatf("%s got %h exp %h", m, g, e));
	endtask : chk

	task automatic chk_word(input e1m_word_t g, input e1m_word_t e);
		comparisons++;
		if (g !== e) bad($sformatf("word got %h exp %h", g, e));
	endtask : chk_word

	task automatic close_out();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out

	// Words taken at the next rising edge
	always @(negedge pclk) begin
		if (mux_frame_pulse_out === 1'b1) n_fp++;
		if (slot_valid === 1'b1 && slot_ready === 1'b1) begin
			if (drop) n_drain++;
			else if (exq.size() == 0) bad("unexpected word");
			else chk_word(slot_word, exq.pop_front());
		end
	end

	task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// Pready, read data and slverr as sampled at the rising edge
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20) begin
			bad("no pready");
			close_out();
		end
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic ee);
		apb(1'b0, a, 32'h0);
		chk(r & m, e, "read");
		chk({31'h0, err}, {31'h0, ee}, "slverr");
	endtask : rd

	task automatic setcfg();
		for (int f = 0; f < 8; f++) apb(1'b1, `E1M_CFG_BASE + 8'(4 * f), 32'(cfgs[f]));
	endtask : setcfg

	// Lowest framer wins, as the note settles clashes
	task automatic expect_frame(input int nb);
		e1m_word_t w;
		int x, fw;
		bit hit;
		logic [7:0] s;
		for (int i = 0; i < nb; i++) begin
			for (int b = 0; b < 2; b++) begin
				hit = 0;
				fw = 0;
				for (int f = 7; f >= 0; f--) begin
					x = (i - int'(cfgs[f].offset)) & 127;
					if (cfgs[f].bus == b[0] && x % 4 == 0) begin
						hit = 1;
						fw = f;
						w.framer = 3'(f);
						w.slot = 5'(x >> 2);
					end
				end
				s = u_bus.pat(b, i, 1);
				w.sig = s[3:0];
				w.data = u_bus.pat(b, i, 0);
				if (w.slot == `E1M_TS16 && !cfgs[fw].common_channel_signaling && !cfgs[fw].sig_src) w.data = s;
				if (hit) exq.push_back(w);
			end
		end
	endtask : expect_frame

	task automatic frame(input string nm, input int nb, input bit dbl, input bit ph,
		input bit inv, input bit ex);
		int n;
		if (ex) expect_frame(nb);
		u_bus.send(nb, dbl, ph, inv);
		repeat (20) @(negedge pclk);
		n = 0;
		while ((exq.size() != 0 || slot_valid === 1'b1) && n < 4000) begin
			@(negedge pclk);
			n++;
		end
		// Back on a rising edge before any bus call
		@(posedge pclk);
		chk(32'(exq.size()), 32'h0, "words missing");
		$display("test %s done", nm);
		if (n >= 4000) begin
			bad("frame hang");
			close_out();
		end
	endtask : frame

	// ****
	// Test sequence
	// ****
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int f = 0; f < 8; f++) rd(`E1M_CFG_BASE + 8'(4 * f), 32'hffff, 32'h0, 1'b0);
		rd(`E1M_STATUS_OFS, 32'h3f03, 32'h0, 1'b0);
		rd(`E1M_CTRL_OFS, 32'h1, 32'h0, 1'b0);
		rd(8'h28, 32'hffffffff, 32'h0, 1'b1);
		rd(8'h02, 32'hffffffff, 32'h0, 1'b1);
		apb(1'b1, 8'h1c, 32'hffff);
		rd(8'h1c, 32'hffff, 32'hffff, 1'b0);
		$display("test registers done");
		cfgs = '0;
		for (int f = 0; f < 4; f++) begin
			cfgs[f].offset = 7'(f);
			cfgs[f + 4].bus = 1'b1;
			cfgs[f + 4].offset = 7'((f + 1) % 4);
		end
		cfgs[0].common_channel_signaling = 1'b1;
		cfgs[1].sig_src = 1'b1;
		setcfg();
		slot_ready <= 1'b1;
		frame("disabled", 4, 0, 0, 0, 0);
		apb(1'b1, `E1M_CTRL_OFS, 32'h1);
		n_fp = 0;
		frame("main", 68, 0, 0, 0, 1);
		chk(32'(n_fp), 32'h1, "pulse out");
		for (int f = 0; f < 8; f++) begin
			cfgs[f].fe = 1'b1;
			cfgs[f].fp_pol = 1'b1;
			if (f < 4) cfgs[f].offset = 7'((f + 2) % 4);
		end
		setcfg();
		frame("edges", 8, 0, 0, 1, 1);
		for (int f = 0; f < 8; f++) cfgs[f].de = 1'b1;
		setcfg();
		frame("falling", 8, 0, 0, 1, 1);
		for (int f = 0; f < 8; f++) begin
			cfgs[f].fe = 1'b0;
			cfgs[f].de = 1'b0;
			cfgs[f].fp_pol = 1'b0;
		end
		cfgs[3].rate_dbl = 1'b1;
		cfgs[6].edge_phase = 1'b1;
		setcfg();
		frame("double", 8, 1, 1, 0, 1);
		cfgs[6].edge_phase = 1'b0;
		setcfg();
		frame("double0", 8, 1, 0, 0, 1);
		cfgs[3].rate_dbl = 1'b0;
		setcfg();
		// Stalled drain: FIFO fills, then refuses
		slot_ready <= 1'b0;
		drop = 1;
		u_bus.send(24, 0, 0, 0);
		repeat (20) @(posedge pclk);
		apb(1'b0, `E1M_STATUS_OFS, 32'h0);
		l = int'(r[13:8]);
		chk(r & 32'h1, 32'h1, "overflow");
		chk(32'(l >= `E1M_FIFO_DEPTH), 32'h1, "full level");
		slot_ready <= 1'b1;
		n_drain = 0;
		l = 0;
		while (slot_valid !== 1'b0 && l < 400) begin
			@(posedge pclk);
			l++;
		end
		chk(32'(n_drain >= `E1M_FIFO_DEPTH), 32'h1, "drained");
		if (l >= 400) begin
			bad("drain hang");
			close_out();
		end
		apb(1'b1, `E1M_STATUS_OFS, 32'h1);
		rd(`E1M_STATUS_OFS, 32'h3f01, 32'h0, 1'b0);
		drop = 0;
		$display("test overflow done");
		close_out();
	end
endmodule : e1m_txmux_bench
